// >>> design/power_stage_control_enable.sv
// power stage source select, enables and forced-off logic
// Overview of operation
// - each output takes its command from control bit or direct pin, per select bit
// - output on when its selected source is high: the control bit, or its assigned pin
// - serial timeout forces every power stage off
// - pins one to four drive injector outputs one to four fixed
// - pins five to eight drive ignition outputs one to four fixed
// - pins nine to twelve routable to outputs five to twenty-four
// - two pins routed to one direct-drive selected output hold that output off
// - central enable bit readable in status, written only by enable command
// - per-channel enable cleared by protection, blocks switch-on, set ignored
// - central enable write 1 sets channel enables without active protection
// - central enable write 0 clears all channel enables
// - injector and ignition groups also need their group enable pin high
// - battery overvoltage forces all power stages off while present
// - predriver pull-down and short-to-battery thresholds configurable
// - relay outputs overcurrent mode, pulls and delayed off configurable
// - bridge freewheel, side, bridge mode and delayed off configurable
// - ignition open-load enable, test current and time configurable
// - low-side outputs report on-state and off-state faults
`timescale 1ns/1ps
module power_stage_control_enable (
	input  wire logic        MCLK,           // 50 MHz clock
	input  wire logic        RST_B,          // async reset, low
	input  wire logic [27:0] CTRL_BITS,      // output_control_reg bits
	input  wire logic [27:0] DD_SELECT,      // direct_drive_select_reg
	input  wire logic [19:0] PIN_ROUTE,      // pin_routing_reg, 5b/pin
	input  wire logic [11:0] DIRECT_DRIVE_PIN, // pins 1..12, async
	input  wire logic        INJECTOR_GROUP_ENABLE_PIN, // async
	input  wire logic        IGNITION_GROUP_ENABLE_PIN, // async
	input  wire logic        MSC_TIMEOUT,    // link timeout level
	input  wire logic        BAT_OV,         // battery overvoltage, async
	input  wire logic        ENABLE_CMD_WR,  // enable_command strobe
	input  wire logic        ENABLE_CMD_VAL, // central enable value
	input  wire logic        CH_EN_WR,       // channel_enable_reg write
	input  wire logic [27:0] CH_EN_WDATA,    // channel enable data
	input  wire logic [27:0] PROT_ACTIVE,    // protection active
	input  wire logic        CFG_WR,         // config write strobe
	input  wire logic [1:0]  CFG_SEL,        // config register select
	input  wire logic [15:0] CFG_WDATA,      // config write data
	input  wire logic [6:0]  FAULT_OC,       // low-side overcurrent
	input  wire logic [6:0]  FAULT_OT,       // low-side overtemp
	input  wire logic [6:0]  FAULT_OL,       // low-side open load
	input  wire logic [6:0]  FAULT_SCG,      // low-side short to gnd
	output logic      [23:0] POWER_OUTPUT,   // stage commands 1..24
	output logic      [3:0]  IGNITION_OUTPUT, // ignition commands
	output logic             OPSTAT_OE,      // operating_status_reg OE
	output logic             FORCED_OFF,     // forced off active
	output logic      [27:0] CH_ENABLE,      // channel_enable_reg
	output logic      [5:0]  PREDRV_PULLDN,  // drain_feedback_pin pull
	output logic      [3:0]  PREDRV_SCB_THR, // scb thresholds
	output logic      [6:0]  RELAY_OC_OFF,   // oc switch-off select
	output logic      [6:0]  RELAY_PULL,     // relay off-state pulls
	output logic             RELAY_DLY_OFF,  // delayed off, ch 17
	output logic      [3:0]  BRIDGE_ACT_FW,  // active freewheel
	output logic      [3:0]  BRIDGE_HIGH,    // high side mode
	output logic      [1:0]  BRIDGE_FULL,    // full bridge pairs
	output logic             BRIDGE_DLY_OFF, // delayed off, ch 21
	output logic      [3:0]  IGN_OL_EN,      // open load enable
	output logic      [1:0]  IGN_OL_CUR,     // open load current
	output logic      [1:0]  IGN_OL_TIME,    // open load time
	output logic      [20:0] DIAG_REPORT     // 3b code per ch 1..7
);
	localparam int NCH = pstage_pkg::NCH;
	localparam int NS  = pstage_pkg::NPIN + 3;

	logic [NS-1:0]  sync1_reg;
	logic [NS-1:0]  sync2_reg;
	logic [11:0]    pin_s;
	logic           inj_en_s;
	logic           ign_en_s;
	logic           bat_ov_s;
	logic           oe_reg;
	logic           oe_next;
	logic [NCH-1:0] ch_en_reg;
	logic [NCH-1:0] ch_en_next;
	logic [NCH-1:0] out_reg;
	logic [NCH-1:0] out_next;
	logic           force_off;
	logic [15:0]    predrv_reg;
	logic [15:0]    relay_reg;
	logic [15:0]    bridge_reg;
	logic [15:0]    ign_reg;
	logic [15:0]    predrv_next;
	logic [15:0]    relay_next;
	logic [15:0]    bridge_next;
	logic [15:0]    ign_next;
	logic [20:0]    diag_reg;
	logic [20:0]    diag_next;

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	// two stages for pins and the analog comparator
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= {BAT_OV, IGNITION_GROUP_ENABLE_PIN,
				INJECTOR_GROUP_ENABLE_PIN, DIRECT_DRIVE_PIN};
			sync2_reg <= sync1_reg;
		end
	end

	assign pin_s    = sync2_reg[11:0];
	assign inj_en_s = sync2_reg[12];
	assign ign_en_s = sync2_reg[13];
	assign bat_ov_s = sync2_reg[14];

	// ------------------------------------------------------------
	// forced off conditions
	// ------------------------------------------------------------
	// timeout forces off
	assign force_off = MSC_TIMEOUT | bat_ov_s;

	// ------------------------------------------------------------
	// central and channel enables
	// ------------------------------------------------------------
	// central enable only via command
	always_comb begin
		oe_next = oe_reg;
		if (ENABLE_CMD_WR) begin
			oe_next = ENABLE_CMD_VAL;
		end
	end

	// central enable register, loads every edge
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			oe_reg <= 1'b0;
		end else begin
			oe_reg <= oe_next;
		end
	end

	// channel enable next value, protection has last word
	always_comb begin
		ch_en_next = ch_en_reg;
		if (CH_EN_WR) begin
			ch_en_next = CH_EN_WDATA;
		end
		if (ENABLE_CMD_WR) begin
			ch_en_next = ENABLE_CMD_VAL ? {NCH{1'b1}} : {NCH{1'b0}};
		end
		ch_en_next = ch_en_next & ~PROT_ACTIVE;
	end

	// channel enable register
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			ch_en_reg <= '0;
		end else begin
			ch_en_reg <= ch_en_next;
		end
	end

	// ------------------------------------------------------------
	// per channel source select and gating
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
			logic           pin_lvl;
			logic           pin_bad;
			logic [3:0]     hit;
			logic           grp_ok;
			logic           cmd;
			if (gi < pstage_pkg::NINJ) begin : g_inj
				assign pin_lvl = pin_s[gi];
				assign pin_bad = 1'b0;
				assign hit     = 4'h0;
				assign grp_ok  = inj_en_s;
			end else if (gi >= pstage_pkg::IGN_BASE) begin : g_ign
				assign pin_lvl = pin_s[gi - pstage_pkg::IGN_BASE
					+ pstage_pkg::IGN_PIN];
				assign pin_bad = 1'b0;
				assign hit     = 4'h0;
				assign grp_ok  = ign_en_s;
			end else begin : g_rt
				genvar pj;
				for (pj = 0; pj < pstage_pkg::RPIN; pj = pj + 1) begin : g_p
					assign hit[pj] = PIN_ROUTE[pj*pstage_pkg::ROUTE_W +: pstage_pkg::ROUTE_W]
						== 5'(gi - pstage_pkg::ROUTE_OFS);
				end
				assign pin_lvl = |(hit & pin_s[pstage_pkg::RPIN_LO +: 4]);
				assign pin_bad = (hit & (hit - 4'h1)) != 4'h0;
				assign grp_ok  = 1'b1;
			end
			assign cmd = DD_SELECT[gi] ? (pin_lvl & ~pin_bad)
				: CTRL_BITS[gi];
			assign out_next[gi] = cmd & ch_en_reg[gi] & grp_ok & ~force_off;
		end
	endgenerate

	// registered stage commands
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			out_reg <= '0;
		end else begin
			out_reg <= out_next;
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	// predriver, relay, bridge and ignition config
	always_comb begin
		predrv_next = predrv_reg;
		relay_next  = relay_reg;
		bridge_next = bridge_reg;
		ign_next    = ign_reg;
		if (CFG_WR) begin
			case (CFG_SEL)
				pstage_pkg::CFG_PREDRV: predrv_next = CFG_WDATA;
				pstage_pkg::CFG_RELAY:  relay_next  = CFG_WDATA;
				pstage_pkg::CFG_BRIDGE: bridge_next = CFG_WDATA;
				pstage_pkg::CFG_IGN:    ign_next    = CFG_WDATA;
				default: ;
			endcase
		end
	end

	// configuration registers load their next value every edge
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			predrv_reg <= pstage_pkg::PREDRV_RST;
			relay_reg  <= pstage_pkg::RELAY_RST;
			bridge_reg <= pstage_pkg::BRIDGE_RST;
			ign_reg    <= pstage_pkg::IGN_RST;
		end else begin
			predrv_reg <= predrv_next;
			relay_reg  <= relay_next;
			bridge_reg <= bridge_next;
			ign_reg    <= ign_next;
		end
	end

	// ------------------------------------------------------------
	// low-side diagnosis
	// ------------------------------------------------------------
	// on and off state fault codes
	always_comb begin
		diag_next = '0;
		for (int k = 0; k < pstage_pkg::NLS; k++) begin
			if (FAULT_OT[k]) begin
				diag_next[k*3 +: 3] = pstage_pkg::DG_OT;
			end else if (out_reg[k]) begin
				if (FAULT_OC[k]) begin
					diag_next[k*3 +: 3] = pstage_pkg::DG_OC;
				end
			end else if (FAULT_SCG[k]) begin
				diag_next[k*3 +: 3] = pstage_pkg::DG_SCG;
			end else if (FAULT_OL[k]) begin
				diag_next[k*3 +: 3] = pstage_pkg::DG_OL;
			end
		end
	end

	// diagnosis codes registered once per edge
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			diag_reg <= '0;
		end else begin
			diag_reg <= diag_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// port mapping of registered state, combinational forced off and config fields
	assign POWER_OUTPUT    = out_reg[23:0];
	assign IGNITION_OUTPUT = out_reg[27:24];
	assign OPSTAT_OE       = oe_reg;
	assign FORCED_OFF      = force_off;
	assign CH_ENABLE       = ch_en_reg;
	assign DIAG_REPORT     = diag_reg;
	assign PREDRV_PULLDN   = predrv_reg[pstage_pkg::PD_PULL_LO +: 6];
	assign PREDRV_SCB_THR  = predrv_reg[pstage_pkg::PD_THR_LO +: 4];
	assign RELAY_OC_OFF    = relay_reg[pstage_pkg::RL_OC_LO +: 7];
	assign RELAY_PULL      = relay_reg[pstage_pkg::RL_PULL_LO +: 7];
	assign RELAY_DLY_OFF   = relay_reg[pstage_pkg::RL_DLY];
	assign BRIDGE_ACT_FW   = bridge_reg[pstage_pkg::BR_FW_LO +: 4];
	assign BRIDGE_HIGH     = bridge_reg[pstage_pkg::BR_HS_LO +: 4];
	assign BRIDGE_FULL     = bridge_reg[pstage_pkg::BR_FB_LO +: 2];
	assign BRIDGE_DLY_OFF  = bridge_reg[pstage_pkg::BR_DLY];
	assign IGN_OL_EN       = ign_reg[pstage_pkg::IG_OL_LO +: 4];
	assign IGN_OL_CUR      = ign_reg[pstage_pkg::IG_CUR_LO +: 2];
	assign IGN_OL_TIME     = ign_reg[pstage_pkg::IG_TIM_LO +: 2];
endmodule : power_stage_control_enable

// >>> design/pstage_pkg.sv
// shared constants for the power stage control and enable block
package pstage_pkg;
	// ------------------------------------------------------------
	// channel layout
	// ------------------------------------------------------------
	localparam int NCH      = 28; // POWER_OUTPUT..OUT24 then ignition 1..4
	localparam int NINJ     = 4;  // injector channels 0..3
	localparam int IGN_BASE = 24; // first ignition channel
	localparam int NPIN     = 12; // direct drive pins
	localparam int RPIN     = 4;  // routable pins 9..12
	localparam int RPIN_LO  = 8;  // index of pin 9
	localparam int IGN_PIN  = 4;  // index of pin 5
	localparam int NLS      = 7;  // low-side channels with diagnosis
	// ------------------------------------------------------------
	// pin routing fields
	// ------------------------------------------------------------
	localparam int ROUTE_W   = 5;  // field width per routable pin
	localparam int ROUTE_OFS = 4;  // field value 0 targets channel 4
	localparam logic [4:0] ROUTE_NONE = 5'h1F; // pin not assigned
	// ------------------------------------------------------------
	// configuration selects and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] CFG_PREDRV = 2'h0;
	localparam logic [1:0] CFG_RELAY  = 2'h1;
	localparam logic [1:0] CFG_BRIDGE = 2'h2;
	localparam logic [1:0] CFG_IGN    = 2'h3;
	localparam logic [15:0] PREDRV_RST = 16'h0000;
	localparam logic [15:0] RELAY_RST  = 16'h0000;
	localparam logic [15:0] BRIDGE_RST = 16'h0000;
	localparam logic [15:0] IGN_RST    = 16'h0000;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int PD_PULL_LO = 0; // predriver pull-down, 6 bits
	localparam int PD_THR_LO  = 6; // predriver threshold, 4 bits
	localparam int RL_OC_LO   = 0; // relay switch-off on oc, 7 bits
	localparam int RL_PULL_LO = 7; // relay pull enable, 7 bits
	localparam int RL_DLY     = 14;// delayed off for channel 17
	localparam int BR_FW_LO   = 0; // active freewheel, 4 bits
	localparam int BR_HS_LO   = 4; // high side mode, 4 bits
	localparam int BR_FB_LO   = 8; // full bridge pairs, 2 bits
	localparam int BR_DLY     = 10;// delayed off for channel 21
	localparam int IG_OL_LO   = 0; // open load enable, 4 bits
	localparam int IG_CUR_LO  = 4; // open load current, 2 bits
	localparam int IG_TIM_LO  = 6; // open load time, 2 bits
	// ------------------------------------------------------------
	// diagnosis codes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		DG_NONE = 3'h0,
		DG_OC   = 3'h1,
		DG_OL   = 3'h2,
		DG_SCG  = 3'h3,
		DG_OT   = 3'h4
	} diag_t;
endpackage : pstage_pkg

// >>> tb/pstage_sva.sv
// assertion checker for the power stage control and enable block
`timescale 1ns/1ps
module pstage_sva (
	input wire logic        MCLK,                      // clock
	input wire logic        RST_B,                     // async reset, low
	input wire logic        FORCED_OFF,                // forced off status
	input wire logic        OPSTAT_OE,                 // central enable
	input wire logic        ENABLE_CMD_WR,             // enable command strobe
	input wire logic        ENABLE_CMD_VAL,            // enable command value
	input wire logic        CH_EN_WR,                  // channel enable write
	input wire logic        INJECTOR_GROUP_ENABLE_PIN, // injector group pin
	input wire logic [27:0] DD_SELECT,                 // source select
	input wire logic [27:0] CTRL_BITS,                 // control bits
	input wire logic [27:0] CH_EN_WDATA,               // channel write data
	input wire logic [27:0] PROT_ACTIVE,               // protection active
	input wire logic [27:0] CH_ENABLE,                 // channel enables
	input wire logic [23:0] POWER_OUTPUT,              // stage commands
	input wire logic [3:0]  IGNITION_OUTPUT            // ignition commands
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_B);
	forced_off_a: assert property (
		FORCED_OFF |=> POWER_OUTPUT == 24'h0 && IGNITION_OUTPUT == 4'h0) else $error("stage on while forced off");
	central_on_a: assert property (
		ENABLE_CMD_WR && ENABLE_CMD_VAL |=> OPSTAT_OE && CH_ENABLE == ~$past(PROT_ACTIVE))
		else $error("central enable did not set channels");
	central_off_a: assert property (
		ENABLE_CMD_WR && !ENABLE_CMD_VAL |=> !OPSTAT_OE && CH_ENABLE == 28'h0) else $error("central off missed");
	oe_hold_a: assert property (
		!ENABLE_CMD_WR |=> OPSTAT_OE == $past(OPSTAT_OE)) else $error("central enable moved without command");
	ch_write_a: assert property (
		CH_EN_WR && !ENABLE_CMD_WR |=> CH_ENABLE == ($past(CH_EN_WDATA) & ~$past(PROT_ACTIVE)))
		else $error("channel enable write wrong");
	prot_block_a: assert property (
		|PROT_ACTIVE |=> (CH_ENABLE & $past(PROT_ACTIVE)) == 28'h0) else $error("protected channel enabled");
	enable_gate_a: assert property (
		1'b1 |=> (POWER_OUTPUT & ~$past(CH_ENABLE[23:0])) == 24'h0) else $error("disabled channel on");
	ctrl_path_a: assert property (
		!DD_SELECT[4] && CH_ENABLE[4] && !FORCED_OFF |=> POWER_OUTPUT[4] == $past(CTRL_BITS[4]))
		else $error("control bit not followed");
	inj_group_a: assert property (
		!INJECTOR_GROUP_ENABLE_PIN [*3] |=> POWER_OUTPUT[3:0] == 4'h0) else $error("injector on without group pin");
	cover property (ENABLE_CMD_WR && ENABLE_CMD_VAL);
	cover property (FORCED_OFF);
	cover property (|(PROT_ACTIVE & CH_EN_WDATA) && CH_EN_WR);
endmodule : pstage_sva
bind power_stage_control_enable pstage_sva pstage_sva_inst (.*);

// >>> tb/ecu_host.sv
// engine control unit model driving the direct and group enable pins
`timescale 1ns/1ps
module ecu_host (
	input  wire logic        clk,     // system clock
	input  wire logic [11:0] pin_req, // wanted direct pin levels
	input  wire logic [1:0]  grp_req, // wanted group enables
	output logic      [11:0] pins,    // direct drive pins
	output logic      [1:0]  grp      // injector, ignition enables
);
	// pins rest low as the pull-downs hold them, then move just after an edge
	initial begin
		pins = 12'h000;
		grp = 2'h0;
	end
	always @(posedge clk) begin
		pins <= pin_req;
		grp <= grp_req;
	end
endmodule : ecu_host

// >>> tb/power_stage_control_enable_tb_top.sv
// self-checking bench for the power stage control and enable block
`timescale 1ns/1ps
module power_stage_control_enable_tb_top;
	typedef struct packed {
		logic [27:0] ctrl, dd;
		logic [19:0] route;
		logic [11:0] pin;
		logic [23:0] pout;
		logic [3:0]  iout;
	} row_t;
	logic        mclk, rst_b, msc_timeout, bat_ov, en_wr, en_val, ch_wr, cfg_wr, opstat_oe, forced_off;
	logic        relay_dly_off, bridge_dly_off;
	logic [1:0]  cfg_sel, grp_req, grp, bridge_full, ign_ol_cur, ign_ol_time;
	logic [11:0] pin_req, pins;
	logic [15:0] cfg_wdata;
	logic [19:0] pin_route;
	logic [27:0] ctrl_bits, dd_select, ch_wdata, prot_active, ch_enable;
	logic [6:0]  fault_oc, fault_ot, fault_ol, fault_scg, relay_oc_off, relay_pull;
	logic [23:0] power_output;
	logic [20:0] diag_report;
	logic [5:0]  predrv_pulldn;
	logic [3:0]  ignition_output, predrv_scb_thr, bridge_act_fw, bridge_high, ign_ol_en;
	int          num_errors = 0;
	int          checks = 0;
	row_t        rows [6] = '{
		'{28'hA5A5A5A, 28'h0, 20'hFFFFF, 12'h000, 24'h5A5A5A, 4'hA},
		'{28'h000000A, 28'h000000F, 20'hFFFFF, 12'h005, 24'h000005, 4'h0},
		'{28'h5000000, 28'hF000000, 20'hFFFFF, 12'h0A0, 24'h000000, 4'hA},
		'{28'h0000020, 28'h0800010, 20'hFFC13, 12'h300, 24'h800030, 4'h0},
		'{28'h0000400, 28'h0000400, 20'hFFCC6, 12'h300, 24'h000000, 4'h0},
		'{28'h0000400, 28'h0000000, 20'hFFCC6, 12'h300, 24'h000400, 4'h0}};
	power_stage_control_enable power_stage_control_enable_inst (
		.MCLK(mclk), .RST_B(rst_b), .CTRL_BITS(ctrl_bits), .DD_SELECT(dd_select), .PIN_ROUTE(pin_route),
		.DIRECT_DRIVE_PIN(pins), .INJECTOR_GROUP_ENABLE_PIN(grp[0]), .IGNITION_GROUP_ENABLE_PIN(grp[1]),
		.MSC_TIMEOUT(msc_timeout), .BAT_OV(bat_ov), .ENABLE_CMD_WR(en_wr), .ENABLE_CMD_VAL(en_val),
		.CH_EN_WR(ch_wr), .CH_EN_WDATA(ch_wdata), .PROT_ACTIVE(prot_active), .CFG_WR(cfg_wr),
		.CFG_SEL(cfg_sel), .CFG_WDATA(cfg_wdata), .FAULT_OC(fault_oc), .FAULT_OT(fault_ot),
		.FAULT_OL(fault_ol), .FAULT_SCG(fault_scg), .POWER_OUTPUT(power_output),
		.IGNITION_OUTPUT(ignition_output), .OPSTAT_OE(opstat_oe), .FORCED_OFF(forced_off),
		.CH_ENABLE(ch_enable), .PREDRV_PULLDN(predrv_pulldn), .PREDRV_SCB_THR(predrv_scb_thr),
		.RELAY_OC_OFF(relay_oc_off), .RELAY_PULL(relay_pull), .RELAY_DLY_OFF(relay_dly_off),
		.BRIDGE_ACT_FW(bridge_act_fw), .BRIDGE_HIGH(bridge_high), .BRIDGE_FULL(bridge_full),
		.BRIDGE_DLY_OFF(bridge_dly_off), .IGN_OL_EN(ign_ol_en), .IGN_OL_CUR(ign_ol_cur),
		.IGN_OL_TIME(ign_ol_time), .DIAG_REPORT(diag_report));
	ecu_host ecu_host_inst (.clk(mclk), .pin_req(pin_req), .grp_req(grp_req), .pins(pins), .grp(grp));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [27:0] exp, input logic [27:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask : settle
	task automatic end_sim;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim
	// clock and watchdog
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		#20000;
		num_errors++;
		end_sim();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_b, msc_timeout, bat_ov, en_wr, en_val, ch_wr, cfg_wr, cfg_sel, cfg_wdata} = '0;
		{ctrl_bits, dd_select, ch_wdata, prot_active, fault_oc, fault_ot, fault_ol, fault_scg} = '0;
		pin_route = 20'hFFFFF;
		pin_req = 12'h000;
		grp_req = 2'h3;
		settle(8);
		chk("reset", 28'h0, {ch_enable[26:0], opstat_oe});
		@(posedge mclk);
		rst_b <= 1'b1;
		prot_active <= 28'h0000020;
		fault_ot <= 7'h20;
		en_wr <= 1'b1;
		en_val <= 1'b1;
		@(posedge mclk);
		en_wr <= 1'b0;
		ch_wr <= 1'b1;
		ch_wdata <= 28'hFFFFFFF;
		settle(0);
		chk("oe", 28'h1, opstat_oe);
		chk("central_on", 28'hFFFFFDF, ch_enable);
		@(posedge mclk);
		ch_wr <= 1'b0;
		settle(0);
		chk("set_ignored", 28'hFFFFFDF, ch_enable);
		chk("diag_ot", 28'h4, diag_report[17:15]);
		// recovery: clear fault, read diagnosis twice, then re-enable
		@(posedge mclk);
		prot_active <= 28'h0;
		fault_ot <= 7'h00;
		settle(2);
		chk("diag_1", 28'h0, diag_report[17:15]);
		chk("diag_2", 28'h0, diag_report[17:15]);
		@(posedge mclk);
		ch_wr <= 1'b1;
		@(posedge mclk);
		ch_wr <= 1'b0;
		settle(0);
		chk("reenable", 28'hFFFFFFF, ch_enable);
		foreach (rows[i]) begin
			@(posedge mclk);
			ctrl_bits <= rows[i].ctrl;
			dd_select <= rows[i].dd;
			pin_route <= rows[i].route;
			pin_req <= rows[i].pin;
			settle(5);
			chk("route", {rows[i].iout, rows[i].pout}, {ignition_output, power_output});
		end
		@(posedge mclk);
		ctrl_bits <= 28'hFFFFFFF;
		dd_select <= 28'h0;
		msc_timeout <= 1'b1;
		settle(2);
		chk("timeout", 28'h0, {ignition_output, power_output});
		chk("forced", 28'h1, forced_off);
		@(posedge mclk);
		msc_timeout <= 1'b0;
		bat_ov <= 1'b1;
		settle(4);
		chk("overvolt", 28'h0, {ignition_output, power_output});
		@(posedge mclk);
		bat_ov <= 1'b0;
		settle(4);
		chk("resume", 28'hFFFFFFF, {ignition_output, power_output});
		@(posedge mclk);
		fault_oc <= 7'h01;
		fault_scg <= 7'h02;
		settle(2);
		chk("diag_on", 28'h01, diag_report[5:0]);
		@(posedge mclk);
		grp_req <= 2'h0;
		fault_ol <= 7'h03;
		settle(5);
		chk("groups", 28'h0FFFFF0, {ignition_output, power_output});
		chk("diag_off", 28'h1A, diag_report[5:0]);
		for (int s = 0; s < 4; s++) begin
			@(posedge mclk);
			cfg_wr <= 1'b1;
			cfg_sel <= 2'(s);
			cfg_wdata <= s[0] ? 16'h2AAA : 16'h5555;
		end
		@(posedge mclk);
		cfg_wr <= 1'b0;
		en_wr <= 1'b1;
		en_val <= 1'b0;
		settle(0);
		chk("predrv", 28'h155, {predrv_scb_thr, predrv_pulldn});
		chk("relay", 28'h2AAA, {relay_dly_off, relay_pull, relay_oc_off});
		chk("bridge", 28'h555, {bridge_dly_off, bridge_full, bridge_high, bridge_act_fw});
		chk("ign_cfg", 28'hAA, {ign_ol_time, ign_ol_cur, ign_ol_en});
		@(posedge mclk);
		en_wr <= 1'b0;
		settle(1);
		chk("central_off", 28'h0, {ch_enable[26:0], opstat_oe});
		chk("all_off", 28'h0, {ignition_output, power_output});
		end_sim();
	end
endmodule : power_stage_control_enable_tb_top
